/* File: scip_pkg.sv */
package scip_pkg;
  localparam logic [7:0] PAGE_ADDR = 8'h01;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;
  localparam logic [7:0] FLAG_ADDR = 8'h11;
  localparam logic [7:0] WIRE_ADDR = 8'h2b;
  localparam int TIMEOUT_BIT = 5;
  localparam int THREE_WIRE_BIT = 3;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] WIRE_CFG_RESET = 8'h00;
  localparam logic [4:0] TGT_ADDR_HI = 5'h1a;
  localparam int FIFO_DEPTH = 8;
  localparam int LINK_PERIOD_NS = 125;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = (TIMEOUT_MS * 1000000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

  typedef enum {S_IDLE, S_ADDR, S_REGA, S_WDAT, S_ACK, S_LOAD, S_RDAT, S_RACK} scip_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } scip_wr_t;

  typedef struct packed {
    logic wr;
    scip_wr_t word;
  } scip_req_t;

  // take a bit once the second and third stage agree
  function automatic logic [5:0] agree(input logic [5:0] s2, input logic [5:0] s3,
                                       input logic [5:0] old);
    return (~(s2 ^ s3) & s3) | ((s2 ^ s3) & old);
  endfunction
endpackage

/* File: scip_top.sv */
`timescale 1ns/100ps
module scip_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = scip_pkg::FIFO_DEPTH
) (
  input logic clock,
  input logic rst_n,
  input logic in_valid,
  output logic in_ready,
  input logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign in_ready = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid = cnt_reg != '0;
  assign out_data = mem[rd_reg];

  always_ff @(posedge clock) begin
    if (push) mem[wr_reg] <= in_data;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      if (pop) rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// Contract
// - Registers use 8-bit addresses within a page, the page byte living at 0x01.
// - The interface-select pin decides whether the two-wire engine is active.
// - Bit 3 of 0x2B picks 3-wire SPI and resets to the 4-wire choice.
// - With the 4-wire choice, writes are still accepted from either SPI wiring.
// - The two-wire side is a 7-bit addressed target only, for 100 and 400 kbps.
// - The target address is a fixed 5-bit upper part plus two address pins.
// - Bytes move most significant bit first, eight bits each.
// - A write carries target address with write bit, register address, then data.
// - Extra write bytes go to successively incremented register addresses.
// - A read first writes the register address, then reads its contents.
// - Several bytes may be read in one read transaction.
// - A stalled bus is detected by timeout and the transaction abandoned.
// - A timeout sets bit 5 of 0x0C and bit 5 of 0x11.
module scip_top #(
  parameter logic [4:0] TGT_ADDR_HI = scip_pkg::TGT_ADDR_HI,
  parameter int TIMEOUT_CYCLES = scip_pkg::TIMEOUT_CYC
) (
  input logic clock,
  input logic rst_n,
  input logic link_clk,
  input logic iface_select_pin,
  input logic target_addr_bit0_pin,
  input logic target_addr_bit1_pin,
  input logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input logic cfg_hold,
  output logic [7:0] page_select,
  output logic three_wire_option,
  output logic timeout_status,
  output logic bus_timeout_sticky_flag,
  output logic i2c_selected
);
  localparam int TCW = $clog2(TIMEOUT_CYCLES + 1);

  // link domain
  logic [2:0] lrst_reg;
  logic link_rst_n;
  logic [5:0] ls1_reg;
  logic [5:0] ls2_reg;
  logic [5:0] ls3_reg;
  logic [5:0] pin_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  scip_pkg::scip_state_t st_reg;
  scip_pkg::scip_state_t st_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic rw_reg;
  logic rw_next;
  logic got_reg;
  logic got_next;
  logic sda_oe_next;
  logic scl_oe_next;
  scip_pkg::scip_req_t req_reg;
  scip_pkg::scip_req_t req_next;
  logic tog_reg;
  logic tog_next;
  logic [TCW-1:0] tcnt_reg;
  logic tmo_live_reg;
  logic low_reg;
  // core domain
  logic [5:0] cs1_reg;
  logic [5:0] cs2_reg;
  logic [5:0] cs3_reg;
  logic [5:0] cag_reg;
  logic seen_reg;
  logic ack_tog_reg;
  logic [7:0] rdata_reg;
  logic [7:0] page_reg;
  logic [7:0] wire_reg;
  logic status_reg;
  logic flag_reg;
  logic [7:0] cfg_mem [256];

  logic scl;
  logic sda;
  logic sel;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic byte_full;
  logic addr_hit;
  logic busy;
  logic tmo_hit;
  assign link_rst_n = lrst_reg[2];
  assign scl = pin_reg[0];
  assign sda = pin_reg[1];
  assign sel = pin_reg[2];
  assign rise = scl & ~scl_d_reg;
  assign fall = ~scl & scl_d_reg;
  assign start = scl & scl_d_reg & sda_d_reg & ~sda;
  assign stop = scl & scl_d_reg & ~sda_d_reg & sda;
  assign byte_full = cnt_reg == 4'h8;
  assign addr_hit = sh_reg[7:1] == {TGT_ADDR_HI, pin_reg[4], pin_reg[3]};
  assign busy = tog_reg != pin_reg[5];
  assign tmo_hit = ~scl & (tcnt_reg == TCW'(TIMEOUT_CYCLES - 1));

  always_ff @(posedge link_clk) begin
    lrst_reg <= {lrst_reg[1:0], rst_n};
    ls1_reg <= {ack_tog_reg, target_addr_bit1_pin, target_addr_bit0_pin,
                iface_select_pin, sda_i, scl_i};
    ls2_reg <= ls1_reg;
    ls3_reg <= ls2_reg;
  end

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    got_next = got_reg;
    sda_oe_next = sda_oe;
    req_next = req_reg;
    tog_next = tog_reg;
    if (!sel || tmo_hit || stop) begin
      st_next = scip_pkg::S_IDLE;
      sda_oe_next = 1'b0;
    end else if (start) begin
      st_next = scip_pkg::S_ADDR;
      cnt_next = '0;
      got_next = 1'b0;
      sda_oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        scip_pkg::S_ADDR, scip_pkg::S_REGA, scip_pkg::S_WDAT: begin
          if (rise && !byte_full) begin
            sh_next = {sh_reg[6:0], sda};
            cnt_next = cnt_reg + 4'h1;
          end
          if (fall && byte_full) begin
            cnt_next = '0;
            sda_oe_next = 1'b1;
            st_next = scip_pkg::S_ACK;
            if (st_reg == scip_pkg::S_ADDR) begin
              rw_next = sh_reg[0];
              if (!addr_hit) begin
                sda_oe_next = 1'b0;
                st_next = scip_pkg::S_IDLE;
              end else if (sh_reg[0]) begin
                req_next = {1'b0, ptr_reg, 8'h00};
                tog_next = ~tog_reg;
              end
            end else if (st_reg == scip_pkg::S_REGA) begin
              ptr_next = sh_reg;
              got_next = 1'b1;
            end else begin
              req_next = {1'b1, ptr_reg, sh_reg};
              tog_next = ~tog_reg;
              ptr_next = ptr_reg + 8'h01;
            end
          end
        end
        scip_pkg::S_ACK: begin
          if (fall) begin
            sda_oe_next = 1'b0;
            if (rw_reg) st_next = scip_pkg::S_LOAD;
            else if (got_reg) st_next = scip_pkg::S_WDAT;
            else st_next = scip_pkg::S_REGA;
          end
        end
        scip_pkg::S_LOAD: begin
          if (!busy) begin
            sh_next = rdata_reg;
            sda_oe_next = ~rdata_reg[7];
            cnt_next = '0;
            st_next = scip_pkg::S_RDAT;
          end
        end
        scip_pkg::S_RDAT: begin
          if (fall && cnt_reg == 4'h7) begin
            sda_oe_next = 1'b0;
            st_next = scip_pkg::S_RACK;
          end else if (fall) begin
            cnt_next = cnt_reg + 4'h1;
            sh_next = {sh_reg[6:0], 1'b0};
            sda_oe_next = ~sh_reg[6];
          end
        end
        scip_pkg::S_RACK: begin
          if (rise && sda) begin
            st_next = scip_pkg::S_IDLE;
          end else if (rise) begin
            ptr_next = ptr_reg + 8'h01;
            req_next = {1'b0, ptr_reg + 8'h01, 8'h00};
            tog_next = ~tog_reg;
            st_next = scip_pkg::S_ACK;
          end
        end
        scip_pkg::S_IDLE: begin
        end
      endcase
    end
  end

  // stretch the clock low while the core has not answered
  assign scl_oe_next = busy & sel & ~tmo_live_reg & (scl_oe | ~scl);

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      pin_reg <= 6'h03;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      st_reg <= scip_pkg::S_IDLE;
      cnt_reg <= '0;
      sh_reg <= '0;
      ptr_reg <= '0;
      rw_reg <= 1'b0;
      got_reg <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      req_reg <= '0;
      tog_reg <= 1'b0;
      tcnt_reg <= '0;
      tmo_live_reg <= 1'b0;
      low_reg <= 1'b0;
      i2c_selected <= 1'b0;
    end else begin
      pin_reg <= scip_pkg::agree(ls2_reg, ls3_reg, pin_reg);
      scl_d_reg <= scl;
      sda_d_reg <= sda;
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      got_reg <= got_next;
      sda_oe <= sda_oe_next;
      scl_oe <= scl_oe_next;
      req_reg <= req_next;
      tog_reg <= tog_next;
      tcnt_reg <= (scl || tmo_hit) ? (scl ? '0 : tcnt_reg) : tcnt_reg + 1'b1;
      tmo_live_reg <= tmo_hit | (tmo_live_reg & ~scl);
      i2c_selected <= sel;
    end
  end
  assign scl_o = low_reg;
  assign sda_o = low_reg;

  // core domain
  scip_pkg::scip_wr_t fifo_out;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic req_ev;
  logic accept;
  logic wr_en;
  logic w1c;
  logic [7:0] rd_val;
  assign req_ev = cag_reg[0] != seen_reg;
  assign accept = req_ev & (req_reg.wr ? fifo_in_ready : ~fifo_out_valid);
  assign wr_en = fifo_out_valid & ~cfg_hold;
  assign w1c = wr_en & (fifo_out.addr == scip_pkg::FLAG_ADDR) &
               fifo_out.data[scip_pkg::TIMEOUT_BIT];
  assign rd_val = (req_reg.word.addr == scip_pkg::PAGE_ADDR) ? page_reg :
                  (req_reg.word.addr == scip_pkg::WIRE_ADDR) ? wire_reg :
                  (req_reg.word.addr == scip_pkg::STATUS_ADDR) ?
                    8'(status_reg) << scip_pkg::TIMEOUT_BIT :
                  (req_reg.word.addr == scip_pkg::FLAG_ADDR) ?
                    8'(flag_reg) << scip_pkg::TIMEOUT_BIT :
                  cfg_mem[req_reg.word.addr];

  scip_fifo #(
    .WIDTH($bits(scip_pkg::scip_wr_t)),
    .DEPTH(scip_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(req_ev & req_reg.wr),
    .in_ready(fifo_in_ready),
    .in_data(req_reg.word),
    .out_valid(fifo_out_valid),
    .out_ready(~cfg_hold),
    .out_data(fifo_out)
  );

  always_ff @(posedge clock) begin
    cs1_reg <= {4'h0, tmo_live_reg, tog_reg};
    cs2_reg <= cs1_reg;
    cs3_reg <= cs2_reg;
    if (wr_en) cfg_mem[fifo_out.addr] <= fifo_out.data;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cag_reg <= '0;
      seen_reg <= 1'b0;
      ack_tog_reg <= 1'b0;
      rdata_reg <= '0;
      page_reg <= scip_pkg::PAGE_RESET;
      wire_reg <= scip_pkg::WIRE_CFG_RESET;
      status_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      cag_reg <= scip_pkg::agree(cs2_reg, cs3_reg, cag_reg);
      if (accept) seen_reg <= cag_reg[0];
      if (accept) ack_tog_reg <= ~ack_tog_reg;
      if (accept && !req_reg.wr) rdata_reg <= rd_val;
      if (wr_en && fifo_out.addr == scip_pkg::PAGE_ADDR) page_reg <= fifo_out.data;
      // the wire choice never gates accepted writes
      if (wr_en && fifo_out.addr == scip_pkg::WIRE_ADDR) wire_reg <= fifo_out.data;
      status_reg <= cag_reg[1];
      flag_reg <= cag_reg[1] | (flag_reg & ~w1c);
    end
  end
  assign page_select = page_reg;
  assign three_wire_option = wire_reg[scip_pkg::THREE_WIRE_BIT];
  assign timeout_status = status_reg;
  assign bus_timeout_sticky_flag = flag_reg;

  property p_ack_hit;
    @(posedge link_clk) disable iff (!link_rst_n)
    st_reg == scip_pkg::S_ADDR && fall && byte_full && addr_hit && sel && !stop
      && !start && !tmo_hit |=> sda_oe && st_reg == scip_pkg::S_ACK;
  endproperty
  a_ack_hit: assert property (p_ack_hit) else $error("own address not acked");
  property p_nack_miss;
    @(posedge link_clk) disable iff (!link_rst_n)
    st_reg == scip_pkg::S_ADDR && fall && byte_full && !addr_hit |=> !sda_oe;
  endproperty
  a_nack_miss: assert property (p_nack_miss) else $error("foreign address acked");
  property p_wr_incr;
    @(posedge link_clk) disable iff (!link_rst_n)
    st_reg == scip_pkg::S_WDAT && fall && byte_full && sel && !stop && !tmo_hit
      |=> ptr_reg == $past(ptr_reg) + 8'h01 && req_reg.wr;
  endproperty
  a_wr_incr: assert property (p_wr_incr) else $error("write address not advanced");
  property p_rd_incr;
    @(posedge link_clk) disable iff (!link_rst_n)
    st_reg == scip_pkg::S_RACK && rise && !sda && sel && !stop && !tmo_hit
      |=> ptr_reg == $past(ptr_reg) + 8'h01 && busy;
  endproperty
  a_rd_incr: assert property (p_rd_incr) else $error("read address not advanced");
  property p_msb;
    @(posedge link_clk) disable iff (!link_rst_n)
    st_reg == scip_pkg::S_LOAD && !busy && sel && !stop && !start && !tmo_hit
      |=> sda_oe == ~$past(rdata_reg[7]);
  endproperty
  a_msb: assert property (p_msb) else $error("first bit is not msb");
  property p_sel_off;
    @(posedge link_clk) disable iff (!link_rst_n)
    !sel |=> st_reg == scip_pkg::S_IDLE && !sda_oe ##1 !scl_oe;
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("engine active when deselected");
  property p_tmo;
    @(posedge link_clk) disable iff (!link_rst_n)
    tmo_hit |=> st_reg == scip_pkg::S_IDLE && !sda_oe && tmo_live_reg ##1 !scl_oe;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout did not abandon");
  property p_flag;
    @(posedge clock) disable iff (!rst_n)
    cag_reg[1] |=> bus_timeout_sticky_flag && timeout_status;
  endproperty
  a_flag: assert property (p_flag) else $error("timeout bits not set");
  property p_sticky;
    @(posedge clock) disable iff (!rst_n)
    flag_reg && !w1c |=> flag_reg;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost without clear");
  property p_wire_rst;
    @(posedge clock) !rst_n |=> !three_wire_option;
  endproperty
  a_wire_rst: assert property (p_wire_rst) else $error("wire option not reset");
  c_burst: cover property (@(posedge link_clk) st_reg == scip_pkg::S_RACK && rise && !sda);
  c_tmo: cover property (@(posedge link_clk) tmo_hit);
  c_full: cover property (@(posedge clock) !fifo_in_ready);
  c_stretch: cover property (@(posedge link_clk) scl_oe);
endmodule

/* File: scip_host_model.sv */
`timescale 1ns/100ps
module scip_host_model #(
  parameter int HALF = 6
) (
  input wire logic link_clk,
  input wire logic scl_w,
  input wire logic sda_w,
  output logic scl_drv,
  output logic sda_drv
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge link_clk);
  endtask

  // release scl, then wait out any stretch the target applies
  task automatic scl_high();
    scl_drv <= 1'b1;
    @(posedge link_clk);
    while (scl_w !== 1'b1) @(posedge link_clk);
    wait_cyc(HALF);
  endtask

  task automatic start_cond();
    sda_drv <= 1'b1;
    wait_cyc(2);
    scl_high();
    sda_drv <= 1'b0;
    wait_cyc(HALF);
    scl_drv <= 1'b0;
    wait_cyc(2);
  endtask

  // data moves only while scl is low, sampled at the end of the high phase
  task automatic clock_bit(input logic b, output logic s);
    sda_drv <= b;
    wait_cyc(HALF - 2);
    scl_high();
    s = sda_w;
    scl_drv <= 1'b0;
    wait_cyc(2);
  endtask

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(d[i], s);
    end
    clock_bit(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, d[i]);
    end
    clock_bit(last, s);
  endtask

  task automatic stop_cond();
    sda_drv <= 1'b0;
    wait_cyc(HALF - 2);
    scl_high();
    sda_drv <= 1'b1;
    wait_cyc(HALF);
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  localparam int TO_CYC = 64;
  localparam int LIMIT = 160000;
  logic clock, rst_n, link_clk, sel, a0, a1, cfg_hold;
  logic scl_drv, sda_drv, scl_oe, sda_oe, scl_w, sda_w;
  logic [7:0] page_select;
  logic three_wire_option, timeout_status, bus_timeout_sticky_flag, i2c_selected;
  logic ack;
  logic [7:0] rd;
  logic [6:0] dev;
  int err_total, total_checks, cyc;

  assign scl_w = scl_drv & ~scl_oe;
  assign sda_w = sda_drv & ~sda_oe;

  scip_top #(.TIMEOUT_CYCLES(TO_CYC)) DUT (.clock(clock), .rst_n(rst_n), .link_clk(link_clk),
    .iface_select_pin(sel), .target_addr_bit0_pin(a0), .target_addr_bit1_pin(a1),
    .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe),
    .cfg_hold(cfg_hold), .page_select(page_select), .three_wire_option(three_wire_option),
    .timeout_status(timeout_status), .bus_timeout_sticky_flag(bus_timeout_sticky_flag),
    .i2c_selected(i2c_selected));

  scip_host_model PM (.link_clk(link_clk), .scl_w(scl_w), .sda_w(sda_w),
    .scl_drv(scl_drv), .sda_drv(sda_drv));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    link_clk = 1'b0;
    #37;
    forever #62.5 link_clk = ~link_clk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic wr_regs(input logic [7:0] ra, input logic [7:0] d[$]);
    PM.start_cond();
    PM.send_byte({dev, 1'b0}, ack);
    check("addr ack", {7'h00, ack}, 8'h01);
    PM.send_byte(ra, ack);
    check("reg ack", {7'h00, ack}, 8'h01);
    foreach (d[i]) begin
      PM.send_byte(d[i], ack);
      check("data ack", {7'h00, ack}, 8'h01);
    end
    PM.stop_cond();
    repeat (20) @(posedge clock);
  endtask

  task automatic t_reset();
    check("page", page_select, 8'h00);
    check("wire", {7'h00, three_wire_option}, 8'h00);
    check("status", {7'h00, timeout_status}, 8'h00);
    check("flag", {7'h00, bus_timeout_sticky_flag}, 8'h00);
    check("selected", {7'h00, i2c_selected}, 8'h01);
  endtask

  // host sets the wire bit over the bus and checks the three_wire_option output
  task automatic t_wire();
    wr_regs(scip_pkg::WIRE_ADDR, '{8'h08});
    check("wire", {7'h00, three_wire_option}, 8'h01);
  endtask

  // fifo fills while draining is held; only a long stretch counts, not the per-byte one
  task automatic t_burst();
    logic [7:0] q[$];
    int n;
    int run;
    for (int i = 0; i < 9; i++) q.push_back(8'h10 + i[7:0]);
    @(posedge clock);
    cfg_hold <= 1'b1;
    fork
      wr_regs(scip_pkg::PAGE_ADDR, q);
      begin
        n = 0;
        run = 0;
        while (run < 600 && n < 60000) begin
          @(posedge clock);
          n++;
          run = (scl_oe === 1'b1) ? run + 1 : 0;
        end
        check("stretch", {7'h00, scl_oe}, 8'h01);
        check("held page", page_select, 8'h00);
        cfg_hold <= 1'b0;
      end
    join
    check("page", page_select, 8'h10);
  endtask

  task automatic t_read();
    wr_regs(scip_pkg::PAGE_ADDR, '{});
    PM.start_cond();
    PM.send_byte({dev, 1'b1}, ack);
    check("read ack", {7'h00, ack}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      PM.recv_byte(i == 2, rd);
      check("read data", rd, 8'h10 + i[7:0]);
    end
    PM.stop_cond();
  endtask

  task automatic t_refuse();
    a0 <= 1'b1;
    PM.wait_cyc(10);
    PM.start_cond();
    PM.send_byte({dev, 1'b0}, ack);
    check("other addr", {7'h00, ack}, 8'h00);
    PM.stop_cond();
    a0 <= 1'b0;
    sel <= 1'b0;
    PM.wait_cyc(10);
    check("selected", {7'h00, i2c_selected}, 8'h00);
    PM.start_cond();
    PM.send_byte({dev, 1'b0}, ack);
    check("spi mode", {7'h00, ack}, 8'h00);
    PM.stop_cond();
    sel <= 1'b1;
    PM.wait_cyc(10);
  endtask

  task automatic t_timeout();
    PM.start_cond();
    PM.send_byte({dev, 1'b0}, ack);
    PM.wait_cyc(TO_CYC + 16);
    check("status", {7'h00, timeout_status}, 8'h01);
    check("flag", {7'h00, bus_timeout_sticky_flag}, 8'h01);
    check("sda free", {7'h00, sda_oe}, 8'h00);
    PM.stop_cond();
    check("status", {7'h00, timeout_status}, 8'h00);
    check("flag", {7'h00, bus_timeout_sticky_flag}, 8'h01);
    wr_regs(scip_pkg::FLAG_ADDR, '{8'h20});
    check("flag", {7'h00, bus_timeout_sticky_flag}, 8'h00);
  endtask

  initial begin
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    rst_n = 1'b0;
    sel = 1'b1;
    a0 = 1'b0;
    a1 = 1'b1;
    cfg_hold = 1'b0;
    dev = {scip_pkg::TGT_ADDR_HI, 2'b10};
    // reset must also span several link clock edges
    repeat (250) @(posedge clock);
    rst_n <= 1'b1;
    repeat (400) @(posedge clock);
    t_reset();
    t_wire();
    t_burst();
    t_read();
    t_refuse();
    t_timeout();
    wrap_up();
  end
endmodule
